// *** design/rtca_alarm_regs.sv ***
// alarm setpoint registers with an ahb-lite slave
// Function
// - weekday alarm digit at bits 10-8, binary value zero to six
// - minute tens digit at bits 14-12, value zero to five
// - minute ones digit at bits 11-8, value zero to nine
// - second tens digit at bits 6-4, value zero to five
// - second ones digit at bits 3-0, value zero to nine
// - weekday/hours write takes effect only while write unlock is one
// - unimplemented bits read zero and ignore writes
`timescale 1ns/100ps
module rtca_alarm_regs (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // alarm digits toward the match logic, and the clock write unlock
    output logic      [2:0]  alarm_weekday_digit,
    output logic      [1:0]  alarm_hour_tens,
    output logic      [3:0]  alarm_hour_ones,
    output logic      [2:0]  alarm_minute_tens,
    output logic      [3:0]  alarm_minute_ones,
    output logic      [2:0]  alarm_second_tens,
    output logic      [3:0]  alarm_second_ones,
    output logic             clock_write_unlock
);
    logic [15:0] wdhr_q, wdhr_d;
    logic [15:0] msec_q, msec_d;
    logic        unlock_q, unlock_d;
    logic        wr_pend_q, wr_pend_d;
    logic [7:0]  wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        resp_q, resp_d;
    logic        take;
    logic [7:0]  a;

    assign take = hsel && hready && (htrans == rtca_pkg::HTRANS_NONSEQ
                                     || htrans == rtca_pkg::HTRANS_SEQ);
    assign a    = haddr[7:0];

    // zero wait states: write data lands in the data phase, read data is
    // registered at the address phase so both answer one cycle later
    always_comb begin
        wdhr_d    = wdhr_q;
        msec_d    = msec_q;
        unlock_d  = unlock_q;
        wr_pend_d = take && hwrite;
        wr_addr_d = take ? a : wr_addr_q;
        rdata_d   = 32'h0000_0000;
        // zero wait states and an okay answer, still held in flops so that
        // every bus output leaves a register
        ready_d   = 1'b1;
        resp_d    = 1'b0;
        if (wr_pend_q) begin
            if (wr_addr_q == rtca_pkg::ADDR_WEEKDAY_HOURS) begin
                if (unlock_q) begin
                    wdhr_d = hwdata[15:0] & rtca_pkg::MASK_WEEKDAY_HOURS;
                end
            end else if (wr_addr_q == rtca_pkg::ADDR_MINUTES_SECONDS) begin
                msec_d = hwdata[15:0] & rtca_pkg::MASK_MINUTES_SECONDS;
            end else if (wr_addr_q == rtca_pkg::ADDR_UNLOCK) begin
                unlock_d = hwdata[rtca_pkg::UNLOCK_BIT];
            end
        end
        if (take && !hwrite) begin
            // reads see the value after any write completing this cycle
            if (a == rtca_pkg::ADDR_WEEKDAY_HOURS) begin
                rdata_d = {16'h0000, wdhr_d & rtca_pkg::MASK_WEEKDAY_HOURS};
            end else if (a == rtca_pkg::ADDR_MINUTES_SECONDS) begin
                rdata_d = {16'h0000, msec_d & rtca_pkg::MASK_MINUTES_SECONDS};
            end else if (a == rtca_pkg::ADDR_UNLOCK) begin
                rdata_d = {31'h0000_0000, unlock_d};
            end
        end
    end

    // synchronous reset; the digits come up zero where the device leaves them unknown
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wdhr_q    <= rtca_pkg::RESET_WEEKDAY_HOURS;
            msec_q    <= rtca_pkg::RESET_MINUTES_SECONDS;
            unlock_q  <= rtca_pkg::RESET_UNLOCK;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            ready_q   <= 1'b1;
            resp_q    <= 1'b0;
        end else begin
            wdhr_q    <= wdhr_d;
            msec_q    <= msec_d;
            unlock_q  <= unlock_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q   <= rdata_d;
            ready_q   <= ready_d;
            resp_q    <= resp_d;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = ready_q;
    assign hresp     = resp_q;

    assign alarm_weekday_digit = wdhr_q[rtca_pkg::WEEKDAY_LSB +: 3];
    assign alarm_hour_tens     = wdhr_q[rtca_pkg::HOUR_TENS_LSB +: 2];
    assign alarm_hour_ones     = wdhr_q[rtca_pkg::HOUR_ONES_LSB +: 4];
    assign alarm_minute_tens   = msec_q[rtca_pkg::MINUTE_TENS_LSB +: 3];
    assign alarm_minute_ones   = msec_q[rtca_pkg::MINUTE_ONES_LSB +: 4];
    assign alarm_second_tens   = msec_q[rtca_pkg::SECOND_TENS_LSB +: 3];
    assign alarm_second_ones   = msec_q[rtca_pkg::SECOND_ONES_LSB +: 4];
    assign clock_write_unlock  = unlock_q;

    // assertions
    // low half of the write data and the unlock bit, named so checks can look back
    logic [15:0] hwdata_lo;
    logic        unlock_wbit;
    assign hwdata_lo   = hwdata[15:0];
    assign unlock_wbit = hwdata[rtca_pkg::UNLOCK_BIT];

    // write paths
    a_write_pend_tracks: assert property (@(posedge ref_clk) disable iff (srst)
        take && hwrite
        |=> wr_pend_q && wr_addr_q == $past(a))
        else $error("write address phase not captured");
    a_locked_write_held: assert property (@(posedge ref_clk) disable iff (srst)
        wr_pend_q && wr_addr_q == rtca_pkg::ADDR_WEEKDAY_HOURS && !unlock_q
        |=> $stable(wdhr_q))
        else $error("weekday/hours changed while locked");
    a_unlocked_write_lands: assert property (@(posedge ref_clk) disable iff (srst)
        wr_pend_q && wr_addr_q == rtca_pkg::ADDR_WEEKDAY_HOURS && unlock_q
        |=> wdhr_q == ($past(hwdata_lo) & rtca_pkg::MASK_WEEKDAY_HOURS))
        else $error("unlocked weekday/hours write lost");
    a_wdhr_write_only: assert property (@(posedge ref_clk) disable iff (srst)
        !(wr_pend_q && wr_addr_q == rtca_pkg::ADDR_WEEKDAY_HOURS)
        |=> $stable(wdhr_q))
        else $error("weekday/hours changed without a write");
    a_msec_write_lands: assert property (@(posedge ref_clk) disable iff (srst)
        wr_pend_q && wr_addr_q == rtca_pkg::ADDR_MINUTES_SECONDS
        |=> {1'h0, alarm_minute_tens, alarm_minute_ones, 1'h0, alarm_second_tens,
             alarm_second_ones} == ($past(hwdata_lo) & rtca_pkg::MASK_MINUTES_SECONDS))
        else $error("minutes/seconds write lost");
    a_msec_write_only: assert property (@(posedge ref_clk) disable iff (srst)
        !(wr_pend_q && wr_addr_q == rtca_pkg::ADDR_MINUTES_SECONDS)
        |=> $stable(msec_q))
        else $error("minutes/seconds changed without a write");
    a_unlock_write_lands: assert property (@(posedge ref_clk) disable iff (srst)
        wr_pend_q && wr_addr_q == rtca_pkg::ADDR_UNLOCK
        |=> clock_write_unlock == $past(unlock_wbit))
        else $error("unlock write lost");
    a_unlock_write_only: assert property (@(posedge ref_clk) disable iff (srst)
        !(wr_pend_q && wr_addr_q == rtca_pkg::ADDR_UNLOCK)
        |=> $stable(clock_write_unlock))
        else $error("unlock changed without a write");

    // field placement
    a_weekday_field: assert property (@(posedge ref_clk) disable iff (srst)
        alarm_weekday_digit == wdhr_q[10:8])
        else $error("weekday digit misplaced");
    a_hour_fields: assert property (@(posedge ref_clk) disable iff (srst)
        {alarm_hour_tens, alarm_hour_ones} == wdhr_q[5:0])
        else $error("hour digits misplaced");
    a_minute_tens: assert property (@(posedge ref_clk) disable iff (srst)
        alarm_minute_tens == msec_q[14:12])
        else $error("minute tens misplaced");
    a_minute_ones: assert property (@(posedge ref_clk) disable iff (srst)
        alarm_minute_ones == msec_q[11:8])
        else $error("minute ones misplaced");
    a_second_digits: assert property (@(posedge ref_clk) disable iff (srst)
        msec_q[6:0] == {alarm_second_tens, alarm_second_ones})
        else $error("second digits misplaced");
    a_second_ones: assert property (@(posedge ref_clk) disable iff (srst)
        alarm_second_ones == msec_q[3:0])
        else $error("second ones misplaced");
    a_unlock_output: assert property (@(posedge ref_clk) disable iff (srst)
        clock_write_unlock == unlock_q)
        else $error("unlock output differs from its register");
    a_wdhr_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        (wdhr_q & ~rtca_pkg::MASK_WEEKDAY_HOURS) == 16'h0000)
        else $error("weekday/hours reserved bits set");
    a_msec_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
        (msec_q & ~rtca_pkg::MASK_MINUTES_SECONDS) == 16'h0000)
        else $error("minutes/seconds reserved bits set");

    // read paths
    a_read_wdhr_data: assert property (@(posedge ref_clk) disable iff (srst)
        take && !hwrite && a == rtca_pkg::ADDR_WEEKDAY_HOURS
        |=> hrdata == {16'h0000, wdhr_q})
        else $error("weekday/hours read wrong");
    a_read_msec_data: assert property (@(posedge ref_clk) disable iff (srst)
        take && !hwrite && a == rtca_pkg::ADDR_MINUTES_SECONDS
        |=> hrdata == {16'h0000, msec_q})
        else $error("minutes/seconds read wrong");
    a_read_unlock_data: assert property (@(posedge ref_clk) disable iff (srst)
        take && !hwrite && a == rtca_pkg::ADDR_UNLOCK
        |=> hrdata == {31'h0, clock_write_unlock})
        else $error("unlock read wrong");
    a_read_unmapped_zero: assert property (@(posedge ref_clk) disable iff (srst)
        take && !hwrite && a != rtca_pkg::ADDR_WEEKDAY_HOURS
        && a != rtca_pkg::ADDR_MINUTES_SECONDS && a != rtca_pkg::ADDR_UNLOCK
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_read_upper_zero: assert property (@(posedge ref_clk) disable iff (srst)
        take && !hwrite |=> hrdata[31:16] == 16'h0000)
        else $error("read upper half not zero");
    a_read_data_drops: assert property (@(posedge ref_clk) disable iff (srst)
        !(take && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data held past its data phase");

    // reset and bus answer
    a_reset_clears_state: assert property (@(posedge ref_clk)
        srst |=> wdhr_q == rtca_pkg::RESET_WEEKDAY_HOURS
            && msec_q == rtca_pkg::RESET_MINUTES_SECONDS && unlock_q == rtca_pkg::RESET_UNLOCK)
        else $error("reset left a register set");
    a_bus_answer_okay: assert property (@(posedge ref_clk) disable iff (srst)
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule : rtca_alarm_regs

// *** design/rtca_pkg.sv ***
// package: register map and field layout of the alarm value registers
package rtca_pkg;
    // byte addresses of the two registers and the unlock control word
    localparam logic [7:0] ADDR_WEEKDAY_HOURS   = 8'h00;
    localparam logic [7:0] ADDR_MINUTES_SECONDS = 8'h04;
    localparam logic [7:0] ADDR_UNLOCK          = 8'h08;
    // implemented bit masks, everything else reads zero
    localparam logic [15:0] MASK_WEEKDAY_HOURS   = 16'h073F;
    localparam logic [15:0] MASK_MINUTES_SECONDS = 16'h7F7F;
    // field positions
    localparam int WEEKDAY_LSB     = 8;
    localparam int HOUR_TENS_LSB   = 4;
    localparam int HOUR_ONES_LSB   = 0;
    localparam int MINUTE_TENS_LSB = 12;
    localparam int MINUTE_ONES_LSB = 8;
    localparam int SECOND_TENS_LSB = 4;
    localparam int SECOND_ONES_LSB = 0;
    localparam int UNLOCK_BIT      = 0;
    // reset values; hardware leaves them unknown, we pick zero
    localparam logic [15:0] RESET_WEEKDAY_HOURS   = 16'h0000;
    localparam logic [15:0] RESET_MINUTES_SECONDS = 16'h0000;
    localparam logic        RESET_UNLOCK          = 1'b0;
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : rtca_pkg

// *** verif/rtca_alarm_regs_tb.sv ***
// self-checking testbench for the alarm value registers
`timescale 1ns/100ps
module rtca_alarm_regs_tb;
    logic        ref_clk = 1'b0;
    logic        srst    = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  wd, mt, st;
    logic [1:0]  ht;
    logic [3:0]  ho, mo, so;
    logic        unl;
    int          errors          = 0;
    int          samples_checked = 0;
    always #50 ref_clk = ~ref_clk;
    // single slave, so its own ready is the bus ready
    rtca_alarm_regs i_dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alarm_weekday_digit(wd),
        .alarm_hour_tens(ht), .alarm_hour_ones(ho), .alarm_minute_tens(mt),
        .alarm_minute_ones(mo), .alarm_second_tens(st), .alarm_second_ones(so),
        .clock_write_unlock(unl));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // no cycle limit here: a bus that never answers is ended by the watchdog
    task automatic wait_rdy;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
    endtask : wait_rdy
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= rtca_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : xfer
    // read data is taken at the edge closing the data phase, before it returns to zero
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, hrdata, exp);
        chk("read response", {31'h0, hresp}, 32'h0);
    endtask : rd
    task automatic t_reset;
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0, "hours at reset");
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0, "minsec at reset");
        chk("digits at reset", {8'h0, wd, ht, ho, mt, mo, st, so, unl}, 32'h0);
    endtask : t_reset
    task automatic t_locked_hours;
        xfer(rtca_pkg::ADDR_WEEKDAY_HOURS, 1'b1, 32'h0000_0629);
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0, "locked hours");
        xfer(8'h08, 1'b1, 32'hFFFF_FFFF);
        rd(8'h08, 32'h1, "unlock readback");
        xfer(rtca_pkg::ADDR_WEEKDAY_HOURS, 1'b1, 32'hFFFF_FFFF);
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0000_073F, "hours all ones");
        chk("hours digits max", {23'h0, wd, ht, ho}, {23'h0, 3'h7, 2'h3, 4'hF});
        xfer(rtca_pkg::ADDR_WEEKDAY_HOURS, 1'b1, 32'h0000_0629);
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0000_0629, "hours value");
        chk("hours digits", {23'h0, wd, ht, ho}, {23'h0, 3'h6, 2'h2, 4'h9});
    endtask : t_locked_hours
    task automatic t_minsec;
        xfer(rtca_pkg::ADDR_MINUTES_SECONDS, 1'b1, 32'hFFFF_FFFF);
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0000_7F7F, "minsec all ones");
        xfer(rtca_pkg::ADDR_MINUTES_SECONDS, 1'b1, 32'h0000_5948);
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0000_5948, "minsec value");
        chk("min digits", {25'h0, mt, mo}, {25'h0, 3'h5, 4'h9});
        chk("sec digits", {25'h0, st, so}, {25'h0, 3'h4, 4'h8});
    endtask : t_minsec
    // relock, then a blocked write must not disturb the stored hours
    task automatic t_relock;
        xfer(rtca_pkg::ADDR_UNLOCK, 1'b1, 32'h0);
        rd(rtca_pkg::ADDR_UNLOCK, 32'h0, "unlock cleared readback");
        chk("unlock cleared", {31'h0, unl}, 32'h0);
        xfer(rtca_pkg::ADDR_WEEKDAY_HOURS, 1'b1, 32'h0000_0113);
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0000_0629, "hours kept");
        chk("digits kept", {23'h0, wd, ht, ho}, {23'h0, 3'h6, 2'h2, 4'h9});
        xfer(rtca_pkg::ADDR_MINUTES_SECONDS, 1'b1, 32'h0000_0105);
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0000_0105, "minsec unlocked");
        rd(8'h0C, 32'h0, "unmapped read");
        xfer(8'h0C, 1'b1, 32'hFFFF_FFFF);
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0000_0105, "unmapped write ignored");
    endtask : t_relock
    // reset in mid-run, with the unlock set, must bring everything back to zero
    task automatic t_midrst;
        xfer(rtca_pkg::ADDR_UNLOCK, 1'b1, 32'h1);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        chk("digits after reset", {8'h0, wd, ht, ho, mt, mo, st, so, unl}, 32'h0);
        rd(rtca_pkg::ADDR_MINUTES_SECONDS, 32'h0, "minsec after reset");
        xfer(rtca_pkg::ADDR_WEEKDAY_HOURS, 1'b1, 32'h0000_0629);
        rd(rtca_pkg::ADDR_WEEKDAY_HOURS, 32'h0, "locked again after reset");
    endtask : t_midrst
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (1000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_locked_hours();
        t_minsec();
        t_relock();
        t_midrst();
        print_verdict();
    end
endmodule : rtca_alarm_regs_tb
